// ---- common/iosc_pkg.sv ----
`default_nettype none
package iosc_pkg;
    // special-function register addresses
    localparam logic [7:0] CTRL_ADDR = 8'hB2;
    localparam logic [7:0] TRIM_ADDR = 8'hB3;
    // control register fields
    localparam int READY_BIT = 4;
    localparam int SRC_BIT = 3;
    localparam int ON_BIT = 2;
    localparam int DIV_LSB = 0;
    localparam logic [7:0] CTRL_RESET = 8'h14;
    // select zero is the slowest rate, divide by eight
    localparam logic [1:0] DIV_RESET = 2'h0;
    localparam logic SRC_RESET = 1'b0;
    localparam logic ON_RESET = 1'b1;
    // default factory trim; actual part value comes from the trim_factory input
    localparam logic [7:0] TRIM_DEFAULT = 8'h80;
    // oscillator model: base period in clk cycles is TRIM_BASE + (255 - trim) / TRIM_SCALE
    localparam int TRIM_BASE = 2;
    localparam int TRIM_SCALE = 64;
    // start-up time of the oscillator after enable
    localparam int STARTUP_NS = 64;
    localparam int CLK_NS = 8;
    localparam logic [7:0] STARTUP_CYC = 8'((STARTUP_NS + CLK_NS - 1) / CLK_NS);

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } iosc_sfr_req_t;
endpackage : iosc_pkg
`default_nettype wire

// ---- logic/iosc_system_clock_out_ctrl.sv ----
// Contract
// - after reset the internal oscillator is the system clock source.
// - software enables, disables and trims the internal oscillator via its registers.
// - the system clock comes from external, undivided internal or divided internal oscillator.
// - the 8-bit trim value sets the internal oscillator period.
// - the trim register resets to the fixed TRIM_DEFAULT and takes the per-device factory value on the first clock after reset.
// - the 2-bit divide select divides the internal oscillator by 1, 2, 4 or 8.
// - after reset the divide select picks divide by eight.
// - source select one routes the external oscillator, zero the divided internal one.
// - switching source during operation is glitch free when the new source is ready.
// - one control write can both enable the internal oscillator and select it.
`timescale 1ns/10ps
`default_nettype none
module iosc_system_clock_out_ctrl (
    input wire logic clk,
    input wire logic reset,
    input wire iosc_pkg::iosc_sfr_req_t sfr_req,
    input wire logic [7:0] trim_factory,
    input wire logic ext_osc_tick,
    input wire logic ext_osc_ready,
    output logic [7:0] sfr_rdata,
    output logic system_clock_out,
    output logic int_osc_tick
);
    logic [7:0] int_osc_trim_reg, next_trim;
    logic [1:0] system_clock_out_divide_sel, next_div;
    logic system_clock_out_source_sel, next_src;
    logic int_osc_on, next_on;
    logic int_osc_freq_ready, next_ready;
    logic [7:0] startup_cnt, next_startup;
    logic [7:0] osc_cnt, next_osc_cnt;
    logic osc_tick, next_osc_tick;
    logic [2:0] div_cnt, next_div_cnt;
    logic div_tick;
    typedef enum logic [1:0] {SRC_INT, SRC_GAP_EXT, SRC_EXT, SRC_GAP_INT} iosc_src_state_t;
    iosc_src_state_t src_state, next_src_state;
    logic next_clk_out;
    logic [7:0] next_rdata;
    logic trim_loaded, next_trim_loaded;
    logic [7:0] period;

    always_comb begin
        next_trim = int_osc_trim_reg;
        next_div = system_clock_out_divide_sel;
        next_src = system_clock_out_source_sel;
        next_on = int_osc_on;
        next_trim_loaded = 1'b1;
        if (!trim_loaded) begin
            next_trim = trim_factory;
        end
        if (sfr_req.wr && sfr_req.addr == iosc_pkg::CTRL_ADDR) begin
            next_on = sfr_req.wdata[iosc_pkg::ON_BIT];
            next_src = sfr_req.wdata[iosc_pkg::SRC_BIT];
            next_div = sfr_req.wdata[iosc_pkg::DIV_LSB +: 2];
        end
        if (sfr_req.wr && sfr_req.addr == iosc_pkg::TRIM_ADDR) begin
            next_trim = sfr_req.wdata;
        end
    end

    // read mux; unused and unmapped bits read zero
    always_comb begin
        next_rdata = 8'h00;
        if (sfr_req.rd && sfr_req.addr == iosc_pkg::CTRL_ADDR) begin
            // ready only while enabled
            // the enable masks the flag so a disable reads back at once
            next_rdata[iosc_pkg::READY_BIT] = int_osc_freq_ready && int_osc_on;
            next_rdata[iosc_pkg::SRC_BIT] = system_clock_out_source_sel;
            next_rdata[iosc_pkg::ON_BIT] = int_osc_on;
            next_rdata[iosc_pkg::DIV_LSB +: 2] = system_clock_out_divide_sel;
        end else if (sfr_req.rd && sfr_req.addr == iosc_pkg::TRIM_ADDR) begin
            next_rdata = int_osc_trim_reg;
        end
    end

    assign period = 8'(iosc_pkg::TRIM_BASE) + 8'((8'hFF - int_osc_trim_reg) / 8'(iosc_pkg::TRIM_SCALE));

    always_comb begin
        next_osc_cnt = osc_cnt;
        next_osc_tick = 1'b0;
        next_startup = startup_cnt;
        next_ready = 1'b0;
        if (!int_osc_on) begin
            next_osc_cnt = 8'h00;
            next_startup = iosc_pkg::STARTUP_CYC;
        end else begin
            if (osc_cnt >= period - 8'h01) begin
                next_osc_cnt = 8'h00;
                next_osc_tick = 1'b1;
            end else begin
                next_osc_cnt = osc_cnt + 8'h01;
            end
            if (startup_cnt != 8'h00) begin
                next_startup = startup_cnt - 8'h01;
            end
            next_ready = (startup_cnt == 8'h00);
        end
    end

    // divide by 1, 2, 4, 8
    always_comb begin
        next_div_cnt = div_cnt;
        div_tick = 1'b0;
        if (osc_tick) begin
            next_div_cnt = div_cnt + 3'h1;
            unique case (system_clock_out_divide_sel)
                // select zero is the slowest rate
                2'h0: div_tick = &div_cnt;
                2'h1: div_tick = &div_cnt[1:0];
                2'h2: div_tick = div_cnt[0];
                2'h3: div_tick = 1'b1;
            endcase
        end
    end

    // switch only when target ready
    // a switch passes through a gap state that keeps the output quiet for one cycle
    always_comb begin
        next_src_state = src_state;
        unique case (src_state)
            SRC_INT: begin
                if (system_clock_out_source_sel && ext_osc_ready) begin
                    next_src_state = SRC_GAP_EXT;
                end
            end
            SRC_GAP_EXT: begin
                next_src_state = SRC_EXT;
            end
            SRC_EXT: begin
                if (!system_clock_out_source_sel && int_osc_freq_ready) begin
                    next_src_state = SRC_GAP_INT;
                end
            end
            SRC_GAP_INT: begin
                next_src_state = SRC_INT;
            end
        endcase
    end

    // source routing
    // the back-to-back guard keeps every output pulse isolated whatever the source does
    always_comb begin
        next_clk_out = 1'b0;
        unique case (src_state)
            SRC_INT: next_clk_out = div_tick && !system_clock_out;
            SRC_EXT: next_clk_out = ext_osc_tick && !system_clock_out;
            SRC_GAP_EXT, SRC_GAP_INT: next_clk_out = 1'b0;
        endcase
    end

    // register group
    always_ff @(posedge clk) begin
        if (reset) begin
            trim_loaded <= 1'b0;
            int_osc_trim_reg <= iosc_pkg::TRIM_DEFAULT;
            system_clock_out_divide_sel <= iosc_pkg::DIV_RESET;
            system_clock_out_source_sel <= iosc_pkg::SRC_RESET;
            int_osc_on <= iosc_pkg::ON_RESET;
        end else begin
            trim_loaded <= next_trim_loaded;
            int_osc_trim_reg <= next_trim;
            system_clock_out_divide_sel <= next_div;
            system_clock_out_source_sel <= next_src;
            int_osc_on <= next_on;
        end
    end

    // oscillator group; ready follows the start-up counter by one cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            int_osc_freq_ready <= 1'b0;
            startup_cnt <= iosc_pkg::STARTUP_CYC;
            osc_cnt <= 8'h00;
            osc_tick <= 1'b0;
        end else begin
            int_osc_freq_ready <= next_ready;
            startup_cnt <= next_startup;
            osc_cnt <= next_osc_cnt;
            osc_tick <= next_osc_tick;
        end
    end

    // divider group; free running so a new select applies at once
    always_ff @(posedge clk) begin
        if (reset) begin
            div_cnt <= 3'h0;
        end else begin
            div_cnt <= next_div_cnt;
        end
    end

    // source group; the internal path drives the output out of reset
    always_ff @(posedge clk) begin
        if (reset) begin
            src_state <= SRC_INT;
        end else begin
            src_state <= next_src_state;
        end
    end

    // output group
    always_ff @(posedge clk) begin
        if (reset) begin
            sfr_rdata <= 8'h00;
            system_clock_out <= 1'b0;
            int_osc_tick <= 1'b0;
        end else begin
            sfr_rdata <= next_rdata;
            system_clock_out <= next_clk_out;
            int_osc_tick <= next_osc_tick;
        end
    end
endmodule : iosc_system_clock_out_ctrl
`default_nettype wire

// ---- dv/iosc_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module iosc_chk (
    input wire logic clk,
    input wire logic reset,
    input wire iosc_pkg::iosc_sfr_req_t sfr_req,
    input wire logic [7:0] sfr_rdata,
    input wire logic system_clock_out,
    input wire logic int_osc_tick
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence rd_c; sfr_req.rd && sfr_req.addr == iosc_pkg::CTRL_ADDR; endsequence
    sequence rd_t; sfr_req.rd && sfr_req.addr == iosc_pkg::TRIM_ADDR; endsequence
    sequence wr_c; sfr_req.wr && sfr_req.addr == iosc_pkg::CTRL_ADDR; endsequence
    sequence wr_t; sfr_req.wr && sfr_req.addr == iosc_pkg::TRIM_ADDR; endsequence
    reset_quiet_a: assert property ($past(reset) |-> !system_clock_out && !int_osc_tick)
        else $error("clock pulse right after reset");
    rdata_idle_a: assert property (!sfr_req.rd |=> sfr_rdata == 8'h00)
        else $error("read data without read");
    unmapped_read_a: assert property (sfr_req.rd && sfr_req.addr != iosc_pkg::CTRL_ADDR
        && sfr_req.addr != iosc_pkg::TRIM_ADDR |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    ctrl_top_a: assert property (rd_c |=> sfr_rdata[7:5] == 3'h0)
        else $error("unused control bits not zero");
    trim_back_a: assert property (wr_t ##1 rd_t |=> sfr_rdata == $past(sfr_req.wdata, 2))
        else $error("trim read back differs");
    ctrl_back_a: assert property (wr_c ##1 rd_c |=> ((sfr_rdata ^ $past(sfr_req.wdata, 2)) & 8'h0F) == 8'h00)
        else $error("control read back differs");
    osc_pulse_a: assert property (int_osc_tick |=> !int_osc_tick)
        else $error("oscillator tick too long");
    sys_pulse_a: assert property (system_clock_out |=> !system_clock_out)
        else $error("system clock glitch");
endmodule : iosc_chk
`default_nettype wire

// ---- dv/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic reset = 1'b1;
    iosc_pkg::iosc_sfr_req_t req = '0;
    logic [1:0] ph = 2'h0;
    logic ext_tick = 1'b0;
    logic ext_ready = 1'b1;
    logic [7:0] rdata;
    logic sys_tick;
    logic osc_tick;
    logic [7:0] n;
    int err_total = 0;
    int num_checks = 0;
    iosc_system_clock_out_ctrl iosc_system_clock_out_ctrl_i (.clk(clk), .reset(reset), .sfr_req(req), .trim_factory(8'h5A),
        .ext_osc_tick(ext_tick), .ext_osc_ready(ext_ready), .sfr_rdata(rdata), .system_clock_out(sys_tick),
        .int_osc_tick(osc_tick));
    always #4 clk = ~clk;
    always @(negedge clk) begin
        ph <= ph + 2'h1;
        ext_tick <= ph == 2'h0;
    end
    initial begin
        #200000;
        err_total++;
        results();
    end
    task cmp(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    // optional write, then read back and compare under a mask
    task acc(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] m, input logic [7:0] e);
        @(negedge clk);
        if (w) begin
            req = '{1'b1, 1'b0, a, d};
            @(negedge clk);
        end
        req = '{1'b0, 1'b1, a, 8'h00};
        @(negedge clk);
        req = '0;
        cmp(rdata & m, e);
    endtask : acc
    // cycles between the second and third pulse; 200 when none come
    task per(input logic s);
        repeat (20) @(negedge clk);
        for (int k = 0; k < 3; k++) begin
            n = 8'h00;
            repeat (200) begin
                @(negedge clk);
                n = n + 8'h01;
                if ((s ? sys_tick : osc_tick) === 1'b1) break;
            end
        end
    endtask : per
    function automatic logic [7:0] op(input logic [7:0] t);
        return 8'(iosc_pkg::TRIM_BASE + (255 - int'(t)) / iosc_pkg::TRIM_SCALE);
    endfunction : op
    task t_reset;
        acc(1'b0, iosc_pkg::CTRL_ADDR, 8'h00, 8'hEF, 8'h04);
        acc(1'b0, iosc_pkg::TRIM_ADDR, 8'h00, 8'hFF, 8'h5A);
        per(1'b1);
        cmp(n, 8'(8 * op(8'h5A)));
        acc(1'b0, iosc_pkg::CTRL_ADDR, 8'h00, 8'hFF, 8'h14);
        $display("reset test done");
    endtask : t_reset
    task t_div;
        acc(1'b1, iosc_pkg::TRIM_ADDR, 8'hFF, 8'hFF, 8'hFF);
        for (int d = 0; d < 4; d++) begin
            acc(1'b1, iosc_pkg::CTRL_ADDR, 8'h04 | 8'(d), 8'h0F, 8'h04 | 8'(d));
            per(1'b1);
            cmp(n, 8'(op(8'hFF) * (8 >> d)));
        end
        acc(1'b1, iosc_pkg::TRIM_ADDR, 8'h00, 8'hFF, 8'h00);
        per(1'b0);
        cmp(n, op(8'h00));
        $display("divider test done");
    endtask : t_div
    task t_src;
        ext_ready = 1'b0;
        acc(1'b1, iosc_pkg::CTRL_ADDR, 8'h0F, 8'h0F, 8'h0F);
        per(1'b1);
        cmp(n, op(8'h00));
        ext_ready = 1'b1;
        per(1'b1);
        cmp(n, 8'h04);
        acc(1'b1, iosc_pkg::CTRL_ADDR, 8'h0B, 8'h1F, 8'h0B);
        per(1'b0);
        cmp(n, 8'hC8);
        acc(1'b1, iosc_pkg::CTRL_ADDR, 8'h07, 8'h0F, 8'h07);
        per(1'b1);
        cmp(n, op(8'h00));
        acc(1'b1, iosc_pkg::CTRL_ADDR, 8'hE7, 8'hE0, 8'h00);
        acc(1'b1, 8'hB4, 8'h55, 8'hFF, 8'h00);
        $display("source test done");
    endtask : t_src
    task results;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results
    initial begin
        repeat (6) @(negedge clk);
        reset = 1'b0;
        t_reset();
        t_div();
        t_src();
        results();
    end
endmodule : tb
bind iosc_system_clock_out_ctrl iosc_chk iosc_chk_i (.clk(clk), .reset(reset), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .system_clock_out(system_clock_out), .int_osc_tick(int_osc_tick));
`default_nettype wire
